// File: design/srw_top.sv
// Supervisor: internal reset, reset pin stretch, thermal flags, watchdog.
// Assumes AXI4-Lite master on clk and analog comparators giving clean levels.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "srw_cfg.svh"
module srw_top #(
  parameter int NREG          = 4,
  parameter int WD_TICK_CYC   = 20000,
  parameter int STRETCH_CYC   = `SRW_STRETCH_CYC,
  parameter int FILT_CYC      = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             uv_main,
  input  wire logic             uv_int,
  input  wire logic             uv_pump,
  input  wire logic             uv_if,
  input  wire logic [NREG-1:0]  uv_reg,
  input  wire logic             low_power,
  input  wire logic             temp_over_sd,
  input  wire logic             temp_over_warn,
  input  wire logic             system_reset_pin_n_i,
  output logic                  system_reset_pin_n_o,
  output logic                  system_reset_pin_n_oe,
  output logic                  internal_reset_n,
  output logic                  bridge_off,
  output logic                  aux_off,
  output logic [NREG-1:0]       reg_off,
  output logic                  wd_warning_flag,
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);

  // Saturating filter: level follows input only after FILT_CYC stable cycles
  function automatic logic [7:0] filt_next(input logic [7:0] c, input logic inp);
    filt_next = inp ? ((c == 8'(FILT_CYC)) ? c : c + 8'h01)
                    : ((c == 8'h00) ? c : c - 8'h01);
  endfunction

  logic [1:0]   stretch_select_q;
  logic         ext_soft_reset_enable_q;
  logic [3:0]   wd_delay_sel_q, wd_delay_act_q;
  logic         wd_enable_a_q, wd_reset_enable_q;
  logic         wd_timeout_flag_q, wd_warn_q;
  logic         thermal_shutdown_flag_q, warn_flag_q;
  logic [7:0]   sd_filt_q, wn_filt_q;
  logic         sd_lvl_q, wn_lvl_q, tsd_hold_q;
  logic [31:0]  wd_div_q, stretch_cnt_q;
  logic [4:0]   wd_cnt_q;
  logic         swrst_q;
  logic         irst_q, pin_low_q;
  logic [NREG-1:0] reg_off_q;
  srw_pkg::srw_state_t st_q;
  logic         aw_hold_q, w_hold_q;
  logic [31:0]  awaddr_q, wdata_q;
  logic [3:0]   wstrb_q;
  logic         bvalid_q, rvalid_q;
  logic [31:0]  rdata_q;
  logic [1:0]   bresp_q, rresp_q;

  wire uv_any      = uv_main | uv_int | uv_pump | uv_if | (|uv_reg);
  wire wd_total    = (wd_cnt_q + 5'h1 == 5'(`SRW_WD_BASE) + {1'b0, wd_delay_act_q});
  wire wd_tick     = (wd_div_q == 32'(WD_TICK_CYC - 1));
  wire wd_rst_req  = wd_enable_a_q & wd_reset_enable_q & wd_tick & wd_total;
  wire irst_cause  = uv_any | low_power | swrst_q | tsd_hold_q | wd_rst_req;
  wire [31:0] str_len = 32'(STRETCH_CYC) * 32'({30'h0, stretch_select_q} + 32'h1);

  // bus blocked while internal reset active
  wire bus_ok   = ~irst_q;
  wire do_wr    = aw_hold_q & w_hold_q & ~bvalid_q;
  wire do_rd    = s_axi_arvalid & s_axi_arready;
  wire [31:0] wa = awaddr_q;
  wire wr_ctrl  = do_wr & bus_ok & (wa[7:0] == `SRW_OFF_CTRL) & wstrb_q[0];
  wire wr_wdcfg = do_wr & bus_ok & (wa[7:0] == `SRW_OFF_WDCFG) & wstrb_q[0];
  wire wr_wdst  = do_wr & bus_ok & (wa[7:0] == `SRW_OFF_WDSTAT) & wstrb_q[0];
  wire wr_temp  = do_wr & bus_ok & (wa[7:0] == `SRW_OFF_TEMP) & wstrb_q[0];
  wire wr_hit   = wr_ctrl | wr_wdcfg | wr_wdst | wr_temp;
  wire wd_svc   = wr_wdst & wdata_q[`SRW_WS_SERVICE];
  wire wd_fclr  = wr_wdst & (wdata_q[`SRW_WS_CLR] | wdata_q[`SRW_WS_SOFTCLR]);
  wire sd_clr   = (wr_temp & wdata_q[`SRW_T_CLR_SD]) | low_power;
  wire wn_clr   = (wr_temp & wdata_q[`SRW_T_CLR_WARN]) | low_power;
  wire [7:0] ra = s_axi_araddr[7:0];
  wire rd_hit   = bus_ok & (ra == `SRW_OFF_CTRL || ra == `SRW_OFF_WDCFG ||
                  ra == `SRW_OFF_WDSTAT || ra == `SRW_OFF_TEMP || ra == `SRW_OFF_STATUS);
  wire [31:0] rd_mux =
      (ra == `SRW_OFF_CTRL)   ? {29'h0, ext_soft_reset_enable_q, stretch_select_q} :
      (ra == `SRW_OFF_WDCFG)  ? {26'h0, wd_reset_enable_q, wd_enable_a_q, wd_delay_sel_q} :
      (ra == `SRW_OFF_WDSTAT) ? {30'h0, wd_warn_q, wd_timeout_flag_q} :
      (ra == `SRW_OFF_TEMP)   ? {30'h0, warn_flag_q, thermal_shutdown_flag_q} :
      (ra == `SRW_OFF_STATUS) ? {26'h0, system_reset_pin_n_i, pin_low_q,
                                 3'h0, irst_q} : 32'h0;

  // AXI4-Lite slave; address and data captured in either order
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 32'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= 2'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_wr) begin
        w_hold_q <= 1'b0;
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (do_rd) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_hit ? rd_mux : 32'h0;
        rresp_q  <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_hold_q;
  assign s_axi_wready  = ~w_hold_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // configuration, cleared by power-on reset only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stretch_select_q        <= `SRW_CTRL_RST;
      ext_soft_reset_enable_q <= 1'b0;
      swrst_q                 <= 1'b0;
      wd_delay_sel_q          <= 4'h0;
      wd_enable_a_q           <= 1'b0;
      wd_reset_enable_q       <= 1'b0;
    end else begin
      // command counts only with enable already set
      swrst_q <= wr_ctrl & wdata_q[`SRW_CTRL_SWRST] & ext_soft_reset_enable_q;
      if (wr_ctrl) begin
        stretch_select_q        <= wdata_q[`SRW_CTRL_STR_LSB +: 2];
        ext_soft_reset_enable_q <= wdata_q[`SRW_CTRL_EXTEN];
      end
      if (wr_wdcfg) begin
        wd_delay_sel_q    <= wdata_q[`SRW_WD_DLY_LSB +: 4];
        wd_enable_a_q     <= wdata_q[`SRW_WD_EN];
        wd_reset_enable_q <= wdata_q[`SRW_WD_RSTEN];
      end
    end
  end

  // watchdog tick divider, halted in low power
  // counter; timeout fires on the tick reaching 8+delay
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_div_q       <= 32'h0;
      wd_cnt_q       <= 5'h0;
      wd_delay_act_q <= 4'h0;
    end else begin
      if (low_power | wd_svc | irst_q) begin
        wd_div_q <= 32'h0;
      end else begin
        wd_div_q <= wd_tick ? 32'h0 : wd_div_q + 32'h1;
      end
      if (wd_svc) begin
        wd_cnt_q       <= 5'h0;
        wd_delay_act_q <= wd_delay_sel_q;
      end else if (irst_q | ~wd_enable_a_q) begin
        wd_cnt_q <= 5'h0;
      end else if (wd_tick) begin
        wd_cnt_q <= wd_total ? 5'h0 : wd_cnt_q + 5'h1;
      end
    end
  end

  // flags survive internal reset; hardware set beats clear
  wire wd_to_ev   = wd_enable_a_q & wd_tick & wd_total & ~irst_q;
  wire wd_warn_ev = wd_enable_a_q & wd_tick & ~irst_q &
                    (wd_cnt_q + 5'h2 == 5'(`SRW_WD_BASE) + {1'b0, wd_delay_act_q});
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wd_timeout_flag_q <= 1'b0;
      wd_warn_q         <= 1'b0;
    end else begin
      wd_timeout_flag_q <= wd_to_ev | (wd_timeout_flag_q & ~wd_fclr);
      if (wd_warn_ev) begin
        wd_warn_q <= 1'b1;
      end else if (wd_svc | wd_to_ev | wd_fclr) begin
        wd_warn_q <= 1'b0;
      end
    end
  end
  assign wd_warning_flag = wd_warn_q;

  // thermal filtering; shutdown held until below warning
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sd_filt_q  <= 8'h0;
      wn_filt_q  <= 8'h0;
      sd_lvl_q   <= 1'b0;
      wn_lvl_q   <= 1'b0;
      tsd_hold_q <= 1'b0;
      thermal_shutdown_flag_q <= 1'b0;
      warn_flag_q             <= 1'b0;
    end else begin
      sd_filt_q <= filt_next(sd_filt_q, temp_over_sd);
      wn_filt_q <= filt_next(wn_filt_q, temp_over_warn);
      if (sd_filt_q == 8'(FILT_CYC)) sd_lvl_q <= 1'b1;
      else if (sd_filt_q == 8'h00) sd_lvl_q <= 1'b0;
      if (wn_filt_q == 8'(FILT_CYC)) wn_lvl_q <= 1'b1;
      else if (wn_filt_q == 8'h00) wn_lvl_q <= 1'b0;
      if (sd_lvl_q) tsd_hold_q <= 1'b1;
      else if (~wn_lvl_q) tsd_hold_q <= 1'b0;
      thermal_shutdown_flag_q <= sd_lvl_q | (thermal_shutdown_flag_q & ~sd_clr);
      warn_flag_q             <= wn_lvl_q | (warn_flag_q & ~wn_clr);
    end
  end

  // internal reset and pin stretch sequence
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q          <= srw_pkg::SRW_HOLD;
      irst_q        <= 1'b1;
      pin_low_q     <= 1'b1;
      stretch_cnt_q <= 32'h0;
    end else begin
      case (st_q)
        srw_pkg::SRW_RUN: begin
          if (irst_cause) begin
            st_q      <= srw_pkg::SRW_HOLD;
            irst_q    <= 1'b1;
            pin_low_q <= 1'b1;
          end
        end
        srw_pkg::SRW_HOLD: begin
          stretch_cnt_q <= 32'h0;
          if (~irst_cause) begin
            st_q   <= srw_pkg::SRW_STRETCH;
            irst_q <= 1'b0;
          end
        end
        srw_pkg::SRW_STRETCH: begin
          if (irst_cause) begin
            st_q   <= srw_pkg::SRW_HOLD;
            irst_q <= 1'b1;
          end else if (stretch_cnt_q >= str_len - 32'h1) begin
            st_q      <= srw_pkg::SRW_RUN;
            pin_low_q <= 1'b0;
          end else begin
            stretch_cnt_q <= stretch_cnt_q + 32'h1;
          end
        end
        default: st_q <= srw_pkg::SRW_HOLD;
      endcase
    end
  end

  // regulators after the failing stage off, failing stage kept on; all for core supplies
  logic [NREG-1:0] reg_off_d;
  always_comb begin
    reg_off_d = '0;
    for (int i = 0; i < NREG; i++) begin
      for (int j = 0; j < i; j++) begin
        if (uv_reg[j]) reg_off_d[i] = 1'b1;
      end
      if (uv_main | uv_int | uv_pump | tsd_hold_q) reg_off_d[i] = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_off_q <= '1;
    end else begin
      reg_off_q <= reg_off_d;
    end
  end

  assign internal_reset_n      = ~irst_q;
  // bridges and auxiliaries idle in reset
  assign bridge_off            = irst_q;
  assign aux_off               = irst_q;
  assign reg_off               = reg_off_q;
  assign system_reset_pin_n_o  = 1'b0;
  assign system_reset_pin_n_oe = pin_low_q;

  // Assertions
  stretch_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(irst_q) |-> pin_low_q [*8])
    else $error("reset pin released too early");
  pin_cover_a: assert property (@(posedge clk) disable iff (sys_rst)
    irst_q |-> pin_low_q)
    else $error("pin high during internal reset");
  uv_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    uv_any |=> irst_q)
    else $error("undervoltage did not reset");
  lowpower_a: assert property (@(posedge clk) disable iff (sys_rst)
    low_power |=> irst_q && (!warn_flag_q || $past(wn_lvl_q)))
    else $error("low power not holding reset");
  wd_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == srw_pkg::SRW_RUN && !wd_reset_enable_q &&
     !(uv_any | low_power | swrst_q | tsd_hold_q)) |=> !irst_q)
    else $error("reset without cause");
  wd_flag_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wd_timeout_flag_q && !wd_fclr) |=> wd_timeout_flag_q)
    else $error("timeout flag lost");
  wd_warn_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    wd_warn_ev |=> wd_warn_q)
    else $error("warning flag not set");
  wd_en_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    !wd_enable_a_q |=> !wd_timeout_flag_q || $past(wd_timeout_flag_q))
    else $error("timeout while disabled");
  tsd_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    (thermal_shutdown_flag_q && !sd_clr) |=> thermal_shutdown_flag_q)
    else $error("shutdown flag lost");
  bus_block_a: assert property (@(posedge clk) disable iff (sys_rst)
    (do_rd && irst_q) |=> s_axi_rresp == 2'h2)
    else $error("bus accepted during reset");
  cv_wd_to: cover property (@(posedge clk) disable iff (sys_rst) wd_to_ev);
  cv_stretch: cover property (@(posedge clk) disable iff (sys_rst) $rose(system_reset_pin_n_oe));
  cv_tsd: cover property (@(posedge clk) disable iff (sys_rst) $rose(tsd_hold_q));

endmodule // srw_top

// File: design/srw_cfg.svh
// Offsets, field positions, reset values and timing counts of the supervisor.
// Included by the package users; definitions only.
`ifndef SRW_CFG_SVH
`define SRW_CFG_SVH
`define SRW_OFF_CTRL      32'h00000000
`define SRW_OFF_WDCFG     32'h00000004
`define SRW_OFF_WDSTAT    32'h00000008
`define SRW_OFF_TEMP      32'h0000000C
`define SRW_OFF_STATUS    32'h00000010
// Control: stretch select and soft reset
`define SRW_CTRL_STR_LSB  0
`define SRW_CTRL_EXTEN    2
`define SRW_CTRL_SWRST    3
`define SRW_CTRL_RST      2'h0
// Watchdog configuration
`define SRW_WD_DLY_LSB    0
`define SRW_WD_EN         4
`define SRW_WD_RSTEN      5
// Watchdog status bits
`define SRW_WS_TOUT       0
`define SRW_WS_WARN       1
`define SRW_WS_SERVICE    2
`define SRW_WS_CLR        3
`define SRW_WS_SOFTCLR    4
// Temperature bits
`define SRW_T_SD          0
`define SRW_T_WARN        1
`define SRW_T_CLR_SD      2
`define SRW_T_CLR_WARN    3
// Timing
`define SRW_CLK_HZ        20000000
`define SRW_STRETCH_MS    16
`define SRW_STRETCH_CYC   ((`SRW_CLK_HZ / 1000) * `SRW_STRETCH_MS)
`define SRW_WD_BASE       8
`endif

// File: design/srw_pkg.sv
// Types of the supervisor, reset and watchdog block.
// Used with scoped names only.
package srw_pkg;
  typedef enum logic [1:0] {
    SRW_RUN,
    SRW_HOLD,
    SRW_STRETCH
  } srw_state_t;
endpackage

// File: bench/srw_pin_model.sv
// Open-drain reset wire with its pull-up, plus one external IC on the same line.
// Assumes the supervisor drives low only; the bench decides when the IC pulls.
`timescale 1ns/1ps
module srw_pin_model (
  input  wire logic oe,
  input  wire logic o,
  input  wire logic ext_low,
  output logic      pin_n
);
  // low while driven
  // Released line goes high through the pull-up, never holds a stale value
  assign pin_n = ((oe && !o) || ext_low) ? 1'b0 : 1'b1;
endmodule // srw_pin_model

// File: bench/supervisor_reset_watchdog_test.sv
// Directed bench for the supervisor over AXI4-Lite with the reset wire model.
// Assumes short dividers: tick 4, stretch 10, filter 2 clocks.
`timescale 1ns/1ps
module supervisor_reset_watchdog_test;
  localparam int TK = 4;
  localparam int ST = 10;
  logic        clk, sys_rst, uv_main, uv_int, uv_pump, uv_if, low_power;
  logic [3:0]  uv_reg, reg_off;
  logic        t_sd, t_warn, pin_n, oe, po, irn, bridge_off, aux_off, wd_warn, ext_low;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rs;
  logic [7:0]  cz [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20};
  logic [3:0]  ez [5] = '{4'hF, 4'hF, 4'hF, 4'h0, 4'hC};
  int          n_fail, n_tests, n;

  srw_top #(.WD_TICK_CYC(TK), .STRETCH_CYC(ST), .FILT_CYC(2)) srw_top_i (
    .clk(clk), .sys_rst(sys_rst), .uv_main(uv_main), .uv_int(uv_int),
    .uv_pump(uv_pump), .uv_if(uv_if), .uv_reg(uv_reg), .low_power(low_power),
    .temp_over_sd(t_sd), .temp_over_warn(t_warn), .system_reset_pin_n_i(pin_n),
    .system_reset_pin_n_o(po), .system_reset_pin_n_oe(oe), .internal_reset_n(irn),
    .bridge_off(bridge_off), .aux_off(aux_off), .reg_off(reg_off),
    .wd_warning_flag(wd_warn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  srw_pin_model srw_pin_model_i (.oe(oe), .o(po), .ext_low(ext_low), .pin_n(pin_n));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang();
    n_fail++;
    $display("[FAIL] wait expired");
    stop_test();
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rdr(input logic [31:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic wirn(input logic v, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(negedge clk);
      if (irn === v) return;
    end
    hang();
  endtask

  // Counts cycles of pin drive after the internal reset lifts
  task automatic stretch(input int exp);
    wirn(1'b1, 200);
    n = 0;
    while (oe === 1'b1 && n < 1000) begin
      n++;
      @(negedge clk);
    end
    chk("stretch", n, exp);
  endtask

  // Tick quantisation allows one tick either way
  task automatic warn_at(input int d);
    n = 0;
    while (wd_warn !== 1'b1 && n < 300) begin
      n++;
      @(negedge clk);
    end
    chk("wd_warn_time", (n >= (6 + d) * TK - 2 && n <= (8 + d) * TK + 2), 1);
  endtask

  initial begin
    {uv_reg, uv_if, uv_pump, uv_int, uv_main, low_power, t_sd, t_warn, ext_low} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    n_fail = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    chk("irn_in_por", irn, 1'b0);
    sys_rst <= 1'b0;
    stretch(ST);
    rdr(32'h0);
    chk("ctrl_default", rd, 32'h0);
    repeat (120) @(posedge clk);
    rdr(32'h8);
    chk("wd_idle", rd[1:0], 2'h0);
    rdr(32'h14);
    chk("unmapped", rs, 2'h2);
    ext_low <= 1'b1;
    repeat (4) @(posedge clk);
    rdr(32'h10);
    chk("pin_low_seen", rd[5], 1'b0);
    ext_low <= 1'b0;
    repeat (4) @(posedge clk);
    rdr(32'h10);
    chk("pin_high_seen", rd[5], 1'b1);
    $display("test power-on done");
    for (int i = 0; i < 5; i++) begin
      wr(32'h0, i % 4);
      chk("wr_resp", rs, 2'h0);
      {uv_reg, uv_if, uv_pump, uv_int, uv_main} <= cz[i];
      wirn(1'b0, 10);
      repeat (2) @(negedge clk);
      chk("reg_off", reg_off, ez[i]);
      chk("bridge_off", bridge_off, 1'b1);
      chk("aux_off", aux_off, 1'b1);
      chk("pin_held", pin_n, 1'b0);
      rdr(32'h0);
      chk("bus_refused", rs, 2'h2);
      chk("refused_data", rd, 32'h0);
      {uv_reg, uv_if, uv_pump, uv_int, uv_main} <= '0;
      stretch(ST * (i % 4 + 1));
    end
    $display("test supplies done");
    wr(32'h0, 32'h8);
    n = 0;
    repeat (10) @(negedge clk) n += (irn === 1'b0);
    chk("soft_off", n, 0);
    wr(32'h0, 32'h4);
    wr(32'h0, 32'hC);
    wirn(1'b0, 10);
    stretch(ST);
    $display("test soft reset done");
    t_warn <= 1'b1;
    @(posedge clk);
    t_warn <= 1'b0;
    repeat (6) @(posedge clk);
    rdr(32'hC);
    chk("warn_glitch", rd[1], 1'b0);
    t_warn <= 1'b1;
    repeat (6) @(posedge clk);
    t_warn <= 1'b0;
    repeat (6) @(posedge clk);
    rdr(32'hC);
    chk("warn_latched", rd[1], 1'b1);
    wr(32'hC, 32'h8);
    rdr(32'hC);
    chk("warn_cleared", rd[1], 1'b0);
    t_warn <= 1'b1;
    t_sd <= 1'b1;
    wirn(1'b0, 20);
    @(posedge clk);
    t_sd <= 1'b0;
    repeat (20) @(negedge clk);
    chk("sd_hold", irn, 1'b0);
    chk("sd_reg_off", reg_off, 4'hF);
    @(posedge clk);
    t_warn <= 1'b0;
    stretch(ST);
    rdr(32'hC);
    chk("sd_flag", rd[1:0], 2'h3);
    wr(32'hC, 32'h4);
    rdr(32'hC);
    chk("sd_cleared", rd[1:0], 2'h2);
    low_power <= 1'b1;
    wirn(1'b0, 10);
    repeat (30) @(negedge clk);
    chk("lp_hold", irn, 1'b0);
    @(posedge clk);
    low_power <= 1'b0;
    stretch(ST);
    rdr(32'hC);
    chk("lp_clears", rd[1:0], 2'h0);
    $display("test thermal done");
    wr(32'h4, 32'h10);
    wr(32'h8, 32'h4);
    warn_at(0);
    // Warning must lead the timeout by exactly one tick
    n = 0;
    while (wd_warn === 1'b1 && n < 50) begin
      n++;
      @(negedge clk);
    end
    chk("wd_warn_lead", n, TK);
    repeat (2 * TK) @(negedge clk);
    rdr(32'h8);
    chk("wd_timeout", rd[0], 1'b1);
    chk("wd_no_rst", irn, 1'b1);
    wr(32'h4, 32'h14);
    wr(32'h8, 32'hC);
    rdr(32'h8);
    chk("wd_clr", rd[0], 1'b0);
    warn_at(4);
    wr(32'h4, 32'h34);
    wr(32'h8, 32'h4);
    wirn(1'b0, 80);
    wirn(1'b1, 200);
    wr(32'h4, 32'h0);
    rdr(32'h8);
    chk("wd_flag_kept", rd[0], 1'b1);
    wr(32'h8, 32'h10);
    rdr(32'h8);
    chk("wd_soft_clr", rd[0], 1'b0);
    $display("test watchdog done");
    stop_test();
  end
endmodule // supervisor_reset_watchdog_test
